// ---- esb_pkg.sv ----
// package of constants for the sticky error-status bank
// Operation
// - any throttling above zero sets bit 0
// - throttle percentage sets one of five bins
// - full hundred percent throttle sets bit 6
// - throttle above user limit sets bit 7
// - only user-limit throttle bit, pins and fans feed management summary
// - low general pin sets its error bit
// - fan count above limit sets bit
// - any host bit raises host summary
// - throttle bins never raise host summary
// - error bits stay set until cleared
// - clear ignored while condition still present
// - events suppressed in their listed sleep states
// - optional masking follows sleep mask bits
// - zones 1 and 2 optionally masked S3, S4/5
// - zones 3 and 4 never sleep masked
// - regulator-hot inputs set bits 4 and 5
// - voltage inputs outside limits set bits
// - all status registers reset to zero
package esb_pkg;
   // ************************************************
   // register offsets
   // ************************************************
   localparam logic [7:0] ESB_OFF_PROC2_THR  = 8'h45;
   localparam logic [7:0] ESB_OFF_INPUT_PIN  = 8'h46;
   localparam logic [7:0] ESB_OFF_FAN        = 8'h47;
   localparam logic [7:0] ESB_OFF_HOST_ZONE  = 8'h48;
   localparam logic [7:0] ESB_OFF_HOST_VOLT  = 8'h49;
   // ************************************************
   // reset values and implemented bits
   // ************************************************
   localparam logic [7:0] ESB_RESET_VALUE    = 8'h00;
   localparam logic [7:0] ESB_FAN_IMPL_MASK  = 8'h0F;
   localparam logic [7:0] ESB_ZONE_IMPL_MASK = 8'h3F;
   localparam logic [7:0] ESB_ALL_IMPL_MASK  = 8'hFF;
   // hot inputs idle low, general pins idle high
   localparam logic [9:0] ESB_PIN_IDLE       = 10'h0FF;
   // ************************************************
   // throttle bit positions and bin thresholds (x/256)
   // ************************************************
   localparam int ESB_BIT_THR_ANY        = 0;
   localparam int ESB_BIT_THR_FULL       = 6;
   localparam int ESB_BIT_THR_USER       = 7;
   localparam logic [8:0] ESB_THR_12P5   = 9'h020;
   localparam logic [8:0] ESB_THR_25     = 9'h040;
   localparam logic [8:0] ESB_THR_50     = 9'h080;
   localparam logic [8:0] ESB_THR_75     = 9'h0C0;
   localparam logic [8:0] ESB_THR_100    = 9'h100;
   // ************************************************
   // sleep states
   // ************************************************
   typedef enum logic [1:0] {
      ESB_S0  = 2'h0,
      ESB_S1  = 2'h1,
      ESB_S3  = 2'h3,
      ESB_S45 = 2'h2
   } esb_sleep_t;
endpackage

// ---- esb_sticky_reg.sv ----
// one 8-bit write-one-to-clear sticky status register
`timescale 1ns/1ps
module esb_sticky_reg #(
   parameter logic [7:0] IMPL_MASK = 8'hFF
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // events and clear
   input  wire logic [7:0] set_i,
   input  wire logic [7:0] clr_i,
   // state
   output logic      [7:0] value_o
);
   import esb_pkg::*;
   logic [7:0] value;
   logic [7:0] next_value;

   // live condition blocks clear; set wins over clear
   assign next_value = ((value & ~clr_i) | set_i) & IMPL_MASK;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         value <= ESB_RESET_VALUE;
      end else begin
         value <= next_value;
      end
   end

   assign value_o = value;
endmodule

// ---- esb_throttle_bins.sv ----
// turns a throttle percentage into its bin event bits
`timescale 1ns/1ps
module esb_throttle_bins (
   // measurement
   input  wire logic       active_i,
   input  wire logic [8:0] percent_i,
   input  wire logic [8:0] limit_i,
   // events
   output logic      [7:0] event_o
);
   import esb_pkg::*;
   wire p_lt_12 = percent_i <  ESB_THR_12P5;
   wire p_lt_25 = percent_i <  ESB_THR_25;
   wire p_lt_50 = percent_i <  ESB_THR_50;
   wire p_lt_75 = percent_i <  ESB_THR_75;
   wire p_full  = percent_i >= ESB_THR_100;

   // bins only meaningful while a measurement is valid
   assign event_o[ESB_BIT_THR_ANY] = active_i && (percent_i != 9'h000);
   assign event_o[1] = active_i && p_lt_12;
   assign event_o[2] = active_i && !p_lt_12 && p_lt_25;
   assign event_o[3] = active_i && !p_lt_25 && p_lt_50;
   assign event_o[4] = active_i && !p_lt_50 && p_lt_75;
   assign event_o[5] = active_i && !p_lt_75 && !p_full;
   assign event_o[ESB_BIT_THR_FULL] = active_i && p_full;
   assign event_o[ESB_BIT_THR_USER] = active_i && (percent_i > limit_i);
endmodule

// ---- esb_error_bank.sv ----
// sticky error-status bank with sleep masking and summary flags
`timescale 1ns/1ps
module esb_error_bank (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // register access port
   input  wire logic [7:0]        reg_addr_i,
   input  wire logic              reg_wr_i,
   input  wire logic [7:0]        reg_wdata_i,
   output logic      [7:0]        reg_rdata_o,
   // sleep state and optional masks
   input  wire logic [1:0]        sleep_state_i,
   input  wire logic [7:0]        input_pin_mask_i,
   input  wire logic [7:0]        pin_mask_s1_i,
   input  wire logic [7:0]        pin_mask_s3_i,
   input  wire logic [7:0]        pin_mask_s45_i,
   input  wire logic [3:0]        fan_mask_s1_i,
   input  wire logic [3:0]        fan_mask_s3_i,
   input  wire logic [1:0]        zone_mask_s3_i,
   input  wire logic [1:0]        zone_mask_s45_i,
   // throttle measurement
   input  wire logic              proc2_throttle_valid_i,
   input  wire logic [8:0]        proc2_throttle_pct_i,
   input  wire logic [8:0]        proc2_throttle_limit_i,
   // pins (asynchronous)
   input  wire logic [7:0]        general_pin_n_i,
   input  wire logic              regulator_hot1_in_i,
   input  wire logic              regulator_hot2_in_i,
   // comparator results from the same clock
   input  wire logic [3:0]        fan_over_limit_i,
   input  wire logic [3:0]        zone_out_of_limit_i,
   input  wire logic [7:0]        analog_out_of_limit_i,
   // summary flags
   output logic                   mgmt_summary_error_o,
   output logic                   host_summary_error_o
);
   import esb_pkg::*;

   // ************************************************
   // pin synchronisers
   // ************************************************
   logic [9:0] pin_meta;
   logic [9:0] pin_sync;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_meta <= ESB_PIN_IDLE;
         pin_sync <= ESB_PIN_IDLE;
      end else begin
         pin_meta <= {regulator_hot2_in_i, regulator_hot1_in_i,
                      general_pin_n_i};
         pin_sync <= pin_meta;
      end
   end
   // reset loads the quiet pin levels so no false event follows reset
   wire [7:0] pin_low = ~pin_sync[7:0];
   wire [1:0] reg_hot = pin_sync[9:8];

   // ************************************************
   // sleep decode
   // ************************************************
   wire in_s3  = sleep_state_i == ESB_S3;
   wire in_s45 = sleep_state_i == ESB_S45;

   // one optional mask per sleep state; S0 never masks
   function automatic logic [7:0] sleep_pick(input logic [1:0] state,
                                             input logic [7:0] opt_s1,
                                             input logic [7:0] opt_s3,
                                             input logic [7:0] opt_s45);
      logic [7:0] pick;
      pick = 8'h00;
      if (state == ESB_S1) begin
         pick = opt_s1;
      end else if (state == ESB_S3) begin
         pick = opt_s3;
      end else if (state == ESB_S45) begin
         pick = opt_s45;
      end
      return pick;
   endfunction
   // fixed masking: S3 and S4/5
   wire deep   = in_s3 || in_s45;

   // ************************************************
   // event qualification
   // ************************************************
   wire [7:0] thr_raw;
   esb_throttle_bins u_bins (
      .active_i  (proc2_throttle_valid_i),
      .percent_i (proc2_throttle_pct_i),
      .limit_i   (proc2_throttle_limit_i),
      .event_o   (thr_raw)
   );
   wire [7:0] thr_ev = deep ? 8'h00 : thr_raw;

   wire [7:0] pin_sleep_mask =
      sleep_pick(sleep_state_i, pin_mask_s1_i, pin_mask_s3_i,
                 pin_mask_s45_i);
   wire [7:0] pin_ev = pin_low & ~input_pin_mask_i
                              & ~pin_sleep_mask;

   // fans are always masked in S4/5, optionally in S1 and S3
   wire [7:0] fan_pick =
      sleep_pick(sleep_state_i, {4'h0, fan_mask_s1_i},
                 {4'h0, fan_mask_s3_i}, 8'h0F);
   wire [3:0] fan_ev = fan_over_limit_i & ~fan_pick[3:0];

   wire [7:0] zone_pick =
      sleep_pick(sleep_state_i, 8'h00, {6'h00, zone_mask_s3_i},
                 {6'h00, zone_mask_s45_i});
   wire [1:0] zone12_ev = zone_out_of_limit_i[1:0] & ~zone_pick[1:0];
   wire [1:0] zone34_ev = zone_out_of_limit_i[3:2];
   wire [1:0] hot_ev    = deep ? 2'h0 : reg_hot;

   wire [7:0] volt_ev = deep ? 8'h00 : analog_out_of_limit_i;

   // ************************************************
   // write decode
   // ************************************************
   wire wr_thr  = reg_wr_i && (reg_addr_i == ESB_OFF_PROC2_THR);
   wire wr_pin  = reg_wr_i && (reg_addr_i == ESB_OFF_INPUT_PIN);
   wire wr_fan  = reg_wr_i && (reg_addr_i == ESB_OFF_FAN);
   wire wr_zone = reg_wr_i && (reg_addr_i == ESB_OFF_HOST_ZONE);
   wire wr_volt = reg_wr_i && (reg_addr_i == ESB_OFF_HOST_VOLT);

   // ************************************************
   // status registers
   // ************************************************
   logic [7:0] thr_q;
   logic [7:0] pin_q;
   logic [7:0] fan_q;
   logic [7:0] zone_q;
   logic [7:0] volt_q;

   esb_sticky_reg #(.IMPL_MASK(ESB_ALL_IMPL_MASK)) u_thr (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .set_i   (thr_ev),
      .clr_i   ({8{wr_thr}} & reg_wdata_i),
      .value_o (thr_q)
   );
   esb_sticky_reg #(.IMPL_MASK(ESB_ALL_IMPL_MASK)) u_pin (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .set_i   (pin_ev),
      .clr_i   ({8{wr_pin}} & reg_wdata_i),
      .value_o (pin_q)
   );
   esb_sticky_reg #(.IMPL_MASK(ESB_FAN_IMPL_MASK)) u_fan (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .set_i   ({4'h0, fan_ev}),
      .clr_i   ({8{wr_fan}} & reg_wdata_i),
      .value_o (fan_q)
   );
   esb_sticky_reg #(.IMPL_MASK(ESB_ZONE_IMPL_MASK)) u_zone (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .set_i   ({2'h0, hot_ev, zone34_ev, zone12_ev}),
      .clr_i   ({8{wr_zone}} & reg_wdata_i),
      .value_o (zone_q)
   );
   esb_sticky_reg #(.IMPL_MASK(ESB_ALL_IMPL_MASK)) u_volt (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .set_i   (volt_ev),
      .clr_i   ({8{wr_volt}} & reg_wdata_i),
      .value_o (volt_q)
   );

   // ************************************************
   // read mux and summary flags
   // ************************************************
   wire [7:0] rd_sel =
      (reg_addr_i == ESB_OFF_PROC2_THR) ? thr_q  :
      (reg_addr_i == ESB_OFF_INPUT_PIN) ? pin_q  :
      (reg_addr_i == ESB_OFF_FAN)       ? fan_q  :
      (reg_addr_i == ESB_OFF_HOST_ZONE) ? zone_q :
      (reg_addr_i == ESB_OFF_HOST_VOLT) ? volt_q : 8'h00;

   // registered flags so outputs come from flip-flops
   logic       mgmt_flag;
   logic       host_flag;
   logic [7:0] rdata;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mgmt_flag <= 1'b0;
         host_flag <= 1'b0;
         rdata     <= 8'h00;
      end else begin
         // bins excluded; user-limit bit, pins and fans count
         mgmt_flag <= thr_q[ESB_BIT_THR_USER] | (|pin_q)
                    | (|fan_q);
         host_flag <= (|zone_q) | (|volt_q);
         rdata     <= rd_sel;
      end
   end
   assign mgmt_summary_error_o = mgmt_flag;
   assign host_summary_error_o = host_flag;
   assign reg_rdata_o          = rdata;
endmodule

// ---- esb_error_bank_monitor.sv ----
// assertions on the ports of the error-status bank
`timescale 1ns/1ps
module esb_monitor
   import esb_pkg::*;
(
   // clock, reset and register port
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic       reg_wr_i,
   input wire logic [7:0] reg_rdata_o,
   // events and flags
   input wire logic [1:0] sleep_state_i,
   input wire logic [3:0] fan_over_limit_i,
   input wire logic [3:0] zone_out_of_limit_i,
   input wire logic [7:0] analog_out_of_limit_i,
   input wire logic       mgmt_summary_error_o,
   input wire logic       host_summary_error_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_fan_reserved: assert property (
      reg_addr_i == ESB_OFF_FAN |=> reg_rdata_o[7:4] == 4'h0)
      else $error("fan reserved bits nonzero");
   a_zone_reserved: assert property (
      reg_addr_i == ESB_OFF_HOST_ZONE |=> reg_rdata_o[7:6] == 2'h0)
      else $error("zone reserved bits nonzero");
   a_unmapped_zero: assert property (
      !(reg_addr_i inside {[ESB_OFF_PROC2_THR:ESB_OFF_HOST_VOLT]})
      |=> reg_rdata_o == 8'h00)
      else $error("unmapped read nonzero");
   a_zone_sets: assert property (
      zone_out_of_limit_i[3] && reg_addr_i == ESB_OFF_HOST_ZONE ##1
      reg_addr_i == ESB_OFF_HOST_ZONE |=> reg_rdata_o[3])
      else $error("zone 4 bit not set");
   a_bit_sticky: assert property (
      reg_addr_i == ESB_OFF_HOST_ZONE && !$past(reg_wr_i) &&
      $past(reg_addr_i) == ESB_OFF_HOST_ZONE && reg_rdata_o[3]
      |=> reg_rdata_o[3]) else $error("zone bit lost without write");
   a_host_zone: assert property (
      zone_out_of_limit_i[3] |-> ##2 host_summary_error_o)
      else $error("host flag missing for zone");
   a_host_volt: assert property (
      analog_out_of_limit_i != 8'h00 && sleep_state_i == ESB_S0
      |-> ##2 host_summary_error_o) else $error("host flag missing");
   a_mgmt_fan: assert property (
      fan_over_limit_i != 4'h0 && sleep_state_i == ESB_S0
      |-> ##2 mgmt_summary_error_o) else $error("mgmt flag missing");
endmodule
bind esb_error_bank esb_monitor u_mon (.clk_i, .rst_i, .reg_addr_i,
   .reg_wr_i, .reg_rdata_o, .sleep_state_i, .fan_over_limit_i,
   .zone_out_of_limit_i, .analog_out_of_limit_i, .mgmt_summary_error_o,
   .host_summary_error_o);

// ---- esb_error_bank_tb.sv ----
// self-checking bench for the sticky error-status bank
`timescale 1ns/1ps
module esb_error_bank_tb;
   import esb_pkg::*;
   logic       clk_i = 1'b0, rst_i = 1'b1, wr = 1'b0, tv = 1'b0;
   logic       h1 = 1'b0, h2 = 1'b0, mflag, hflag;
   logic [1:0] st = 2'h0, z3 = 2'h0, z45 = 2'h0;
   logic [3:0] fan = 4'h0, zone = 4'h0, f1 = 4'h0, f3 = 4'h0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, pins = 8'hFF, pm = 8'h00;
   logic [7:0] m1 = 8'h00, m3 = 8'h00, m45 = 8'h00, ana = 8'h00, rdata;
   logic [8:0] tp = 9'h000, tl = 9'h000;
   logic [8:0] tps [8] = '{9'h000, 9'h001, 9'h01F, 9'h020,
                          9'h07F, 9'h0C0, 9'h0FF, 9'h100};
   int         n_fail = 0, check_count = 0, seed = 394, i;
   always #50 clk_i = ~clk_i;
   esb_error_bank u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata), .sleep_state_i(st),
      .input_pin_mask_i(pm), .pin_mask_s1_i(m1), .pin_mask_s3_i(m3),
      .pin_mask_s45_i(m45), .fan_mask_s1_i(f1), .fan_mask_s3_i(f3),
      .zone_mask_s3_i(z3), .zone_mask_s45_i(z45),
      .proc2_throttle_valid_i(tv), .proc2_throttle_pct_i(tp),
      .proc2_throttle_limit_i(tl), .general_pin_n_i(pins),
      .regulator_hot1_in_i(h1), .regulator_hot2_in_i(h2),
      .fan_over_limit_i(fan), .zone_out_of_limit_i(zone),
      .analog_out_of_limit_i(ana), .mgmt_summary_error_o(mflag),
      .host_summary_error_o(hflag));
   task automatic results();
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_flag(string nm, logic e, logic g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask
   // read lands one cycle after the address
   task automatic rc(string nm, logic [7:0] a, logic [7:0] e);
      @(posedge clk_i);
      addr <= a;
      @(posedge clk_i);
      #1 chk(nm, e, rdata);
   endtask
   task automatic wrr(logic [7:0] a, logic [7:0] d);
      @(posedge clk_i);
      {addr, wdata, wr} <= {a, d, 1'b1};
      @(posedge clk_i);
      wr <= 1'b0;
   endtask
   function automatic logic [7:0] thr_exp(logic [8:0] p, logic [8:0] l);
      logic [7:0] e;
      e[0] = p != 9'h000;
      e[1] = p < ESB_THR_12P5;
      e[2] = p >= ESB_THR_12P5 && p < ESB_THR_25;
      e[3] = p >= ESB_THR_25 && p < ESB_THR_50;
      e[4] = p >= ESB_THR_50 && p < ESB_THR_75;
      e[5] = p >= ESB_THR_75 && p < ESB_THR_100;
      e[6] = p == ESB_THR_100;
      e[7] = p > l;
      return e;
   endfunction
   // random events and masks in one sleep state, then read and clear
   task automatic ev_round(logic [1:0] s);
      logic       dp;
      logic [7:0] pe, fe, ze, ve, te;
      @(posedge clk_i);
      st <= s;
      {pins, pm, m1, m3, m45, ana} <= 48'({$random(seed), $random(seed)});
      {fan, zone, f1, f3, z3, z45, h1, h2} <= 22'($random(seed));
      tp <= 9'($unsigned($random(seed)) % 257);
      tl <= 9'($unsigned($random(seed)) % 257);
      tv <= 1'b1;
      repeat (4) @(posedge clk_i);
      dp = s == ESB_S3 || s == ESB_S45;
      te = dp ? 8'h00 : thr_exp(tp, tl);
      pe = ~pins & ~pm & ~(s == ESB_S1 ? m1 : s == ESB_S3 ? m3 :
                           s == ESB_S45 ? m45 : 8'h00);
      fe = {4'h0, fan & ~(s == ESB_S1 ? f1 : s == ESB_S3 ? f3 : {4{dp}})};
      ze = {2'h0, {h2, h1} & {2{!dp}}, zone[3:2], zone[1:0] &
            ~(s == ESB_S3 ? z3 : s == ESB_S45 ? z45 : 2'h0)};
      ve = ana & {8{!dp}};
      pins <= 8'hFF;
      {fan, zone, ana, h1, h2, tv} <= '0;
      rc("thr", ESB_OFF_PROC2_THR, te);
      rc("gpi", ESB_OFF_INPUT_PIN, pe);
      rc("fan", ESB_OFF_FAN, fe);
      rc("zone", ESB_OFF_HOST_ZONE, ze);
      rc("volt", ESB_OFF_HOST_VOLT, ve);
      chk_flag("mflag", |{pe, fe, te[7]}, mflag);
      chk_flag("hflag", |{ze, ve}, hflag);
      for (int a = 'h45; a <= 'h49; a++) wrr(8'(a), 8'hFF);
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      results();
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      for (i = 'h45; i <= 'h4A; i++) rc("reset", 8'(i), 8'h00);
      foreach (tps[k]) begin
         @(posedge clk_i);
         {tp, tv} <= {tps[k], 1'b1};
         tl <= 9'($unsigned($random(seed)) % 257);
         @(posedge clk_i);
         tv <= 1'b0;
         rc("thr", ESB_OFF_PROC2_THR, thr_exp(tps[k], tl));
         chk_flag("mflag", tps[k] > tl, mflag);
         chk_flag("hflag", 1'b0, hflag);
         wrr(ESB_OFF_PROC2_THR, 8'hFF);
      end
      for (i = 0; i < 12; i++) ev_round(2'(i));
      // clear while the fault is still present must not take
      @(posedge clk_i);
      zone <= 4'h8;
      wrr(ESB_OFF_HOST_ZONE, 8'h08);
      zone <= 4'h0;
      wrr(ESB_OFF_HOST_ZONE, 8'h00);
      rc("held", ESB_OFF_HOST_ZONE, 8'h08);
      wrr(ESB_OFF_HOST_ZONE, 8'h08);
      rc("clear", ESB_OFF_HOST_ZONE, 8'h00);
      // reset in mid-run with a bit just set brings the zone register and host flag back to zero
      @(posedge clk_i);
      zone <= 4'h4;
      @(posedge clk_i);
      {zone, rst_i} <= {4'h0, 1'b1};
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rc("rst", ESB_OFF_HOST_ZONE, 8'h00);
      chk_flag("hflag", 1'b0, hflag);
      results();
   end
endmodule
